// >>> design/ugp_blink.sv
/*
  Activity indicator toggler: flips its output every TOGGLE_CYC clocks
  while active is high, and rests high otherwise.
  Assumes active comes from logic on the same clock.
*/
`timescale 1ns/1ns
module ugp_blink #(
  parameter int TOGGLE_CYC = ugp_pkg::ACT_TOGGLE_CYC
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic active,
  output logic      blink
);

  ugp_pkg::ugp_blink_st_t st_r;
  ugp_pkg::ugp_blink_st_t st_nxt;

  // Count while busy; idle keeps the LED dark and restarts the interval
  always_comb begin
    st_nxt = st_r;
    if (!active) begin
      st_nxt.cnt = '0;
      st_nxt.lvl = 1'b1;
    end else if (st_r.cnt >= 32'(TOGGLE_CYC - 1)) begin
      st_nxt.cnt = '0;
      st_nxt.lvl = ~st_r.lvl;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= '{cnt: 32'h0, lvl: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign blink = st_r.lvl;

endmodule // ugp_blink

// >>> design/ugp_otp_mem.sv
/*
  Small one-time-programmable store for pin configuration words.
  Assumes one clock; contents survive every reset, blank words read zero.
*/
`timescale 1ns/1ns
module ugp_otp_mem #(
  parameter int DEPTH = 11,
  parameter int WIDTH = 9,
  parameter int AW    = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data_r
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];

  // Blank fuses read as zero
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = '0;
    end
  end

  // No reset here: programmed words must outlive power-up reset
  always_ff @(posedge sys_clk) begin
    if (wr_en && (int'(wr_addr) < DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_r <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : '0;
  end

endmodule // ugp_otp_mem

// >>> design/ugp_pin_mux.sv
/*
  Pin function selector for the UART-side pins: GPIO versus modem,
  activity, RS-485 and USB status functions, with pin type, pull control,
  one-time-programmed boot configuration and reset behaviour.
  Assumes the USB core and UART share sys_clk and drive ext directly;
  pad inputs are asynchronous and are synchronised here.
*/
// Operation
// - The ring pin is GPIO, ring input or wake input, and boots as a pulled-up GPIO input.
// - The carrier pin is GPIO or carrier input, and boots as a pulled-up GPIO input.
// - Status output B has the same conditions as A and boots low-active on suspend, changeable.
// - The receive indicator pin boots push-pull and toggles about every 100 ms while receiving.
// - The transmit indicator pin boots push-pull and toggles about every 100 ms while sending.
// - The RS-485 pin is GPIO or half-duplex enable, booting as an active-high push-pull enable.
// - The CTS pin is GPIO or CTS input, booting as CTS input with pull-up.
// - The RTS pin is GPIO, RTS output or half-duplex enable, booting as open-drain RTS.
// - Every pin slot takes a pin type from the runtime register or from one-time memory.
// - Enabled pulls stay enabled through USB suspend.
// - One-time memory settings apply from the next power-up reset and then stay.
// - Pulls are off while USB bus reset lasts and return when it ends.
// - Runtime settings are dropped on power-up or bus reset in favour of stored ones.
// - Open-drain outputs keep a weak pull-up outside bus reset so a released line rests high.
// - Status output A can show bus reset, suspend or unsafe-current, with selectable polarity.
// - Status output A boots active high on suspend and is inactive when no condition holds.
`timescale 1ns/1ns
module ugp_pin_mux #(
  parameter int TOGGLE_CYC = ugp_pkg::ACT_TOGGLE_CYC
) (
  input  wire logic                             sys_clk,
  input  wire logic                             sys_rst,
  input  wire logic [ugp_pkg::ADDR_W-1:0]       reg_addr,
  input  wire logic [ugp_pkg::DATA_W-1:0]       reg_wdata,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  output logic      [ugp_pkg::DATA_W-1:0]       reg_rdata,
  input  ugp_pkg::ugp_ext_t                     ext,
  input  wire logic [ugp_pkg::NUM_PINS-1:0]     pad_in,
  output ugp_pkg::ugp_pads_t                    pads,
  output ugp_pkg::ugp_core_in_t                 core_in
);

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic logic in_cfg(input logic [ugp_pkg::ADDR_W-1:0] a);
    in_cfg = (a <= ugp_pkg::A_CFG_LAST);
  endfunction

  function automatic logic in_otp(input logic [ugp_pkg::ADDR_W-1:0] a);
    in_otp = (a >= ugp_pkg::A_OTP_BASE) && (a <= ugp_pkg::A_OTP_LAST);
  endfunction

  // Status pin level from its condition word
  // unmet reads inactive
  function automatic logic stat_level(
    input logic [ugp_pkg::CFG_W-1:0] c,
    input ugp_pkg::ugp_ext_t         e
  );
    logic hit;
    hit = (c[ugp_pkg::ST_C_RESET]  & e.bus_reset)
        | (c[ugp_pkg::ST_C_SUSP]   & e.suspend)
        | (c[ugp_pkg::ST_C_UNSAFE] & e.unsafe);
    stat_level = c[ugp_pkg::ST_POL_HIGH] ? hit : ~hit;
  endfunction

  // ----------------------------------------------------------------------
  // State and submodules
  // ----------------------------------------------------------------------
  ugp_pkg::ugp_top_st_t             st_r;
  ugp_pkg::ugp_top_st_t             st_nxt;
  logic [ugp_pkg::OTP_W-1:0]        otp_rd;
  logic                             otp_write_request;
  logic [ugp_pkg::IDX_W-1:0]        otp_waddr;
  logic                             rx_activity_indicator;
  logic                             tx_activity_indicator;

  // Reset image: defaults everywhere, loader armed
  localparam ugp_pkg::ugp_top_st_t ST_RST = '{
    ld:     ugp_pkg::LD_REQ,
    ld_idx: 4'h0,
    cfg:    ugp_pkg::CFG_DEFAULT,
    boot:   ugp_pkg::CFG_DEFAULT,
    s1:     9'h1ff,
    s2:     9'h1ff,
    s3:     9'h1ff,
    stab:   9'h1ff,
    pads:   '{out: 9'h000, oe: 9'h000, pu: 9'h000, pd: 9'h000},
    core:   '{cts_n: 1'b1, carrier_detect_n: 1'b1,
              ring_indicator_n: 1'b1, remote_wake_in_n: 1'b1},
    rdata:  32'h0000_0000
  };

  assign otp_write_request = reg_wr && in_otp(reg_addr);
  assign otp_waddr = ugp_pkg::IDX_W'(reg_addr - ugp_pkg::A_OTP_BASE);

  ugp_otp_mem #(
    .DEPTH (ugp_pkg::NUM_CFG),
    .WIDTH (ugp_pkg::OTP_W),
    .AW    (ugp_pkg::IDX_W)
  ) u_otp (
    .sys_clk   (sys_clk),
    .wr_en     (otp_write_request),
    .wr_addr   (otp_waddr),
    .wr_data   ({1'b1, reg_wdata[ugp_pkg::CFG_W-1:0]}),
    .rd_addr   (st_r.ld_idx),
    .rd_data_r (otp_rd)
  );

  ugp_blink #(
    .TOGGLE_CYC (TOGGLE_CYC)
  ) u_rx_blink (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .active  (ext.rx_busy),
    .blink   (rx_activity_indicator)
  );

  ugp_blink #(
    .TOGGLE_CYC (TOGGLE_CYC)
  ) u_tx_blink (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .active  (ext.tx_busy),
    .blink   (tx_activity_indicator)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic [1:0]                func;
    logic [1:0]                pull;
    logic                      drive;
    logic                      od;
    logic                      val;
    logic [ugp_pkg::CFG_W-1:0] word;
    func  = 2'h0;
    pull  = 2'h0;
    drive = 1'b0;
    od    = 1'b0;
    val   = 1'b0;
    word  = '0;
    st_nxt = st_r;

    // Pad synchroniser; a level counts once stages two and three agree
    st_nxt.s1 = pad_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < ugp_pkg::NUM_PINS; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.stab[i] = st_r.s3[i];
      end
    end

    // boot loader walks the store once after power-up reset
    case (st_r.ld)
      ugp_pkg::LD_REQ: begin
        st_nxt.ld = ugp_pkg::LD_TAKE;
      end
      ugp_pkg::LD_TAKE: begin
        word = st_r.boot[st_r.ld_idx];
        if (otp_rd[ugp_pkg::OTP_W-1]) begin
          word = otp_rd[ugp_pkg::CFG_W-1:0];
        end
        st_nxt.boot[st_r.ld_idx] = word;
        st_nxt.cfg[st_r.ld_idx]  = word;
        if (st_r.ld_idx == ugp_pkg::IDX_W'(ugp_pkg::NUM_CFG - 1)) begin
          st_nxt.ld = ugp_pkg::LD_DONE;
        end else begin
          st_nxt.ld     = ugp_pkg::LD_REQ;
          st_nxt.ld_idx = st_r.ld_idx + 4'h1;
        end
      end
      ugp_pkg::LD_DONE: begin
        st_nxt.ld = ugp_pkg::LD_DONE;
      end
      default: begin
        st_nxt.ld = ugp_pkg::LD_DONE;
      end
    endcase

    // runtime write lands in the live table immediately
    if (reg_wr && in_cfg(reg_addr) && !ext.bus_reset) begin
      st_nxt.cfg[reg_addr[ugp_pkg::IDX_W-1:0]] =
        reg_wdata[ugp_pkg::CFG_W-1:0];
    end

    // bus reset throws runtime settings back to the boot image
    if (ext.bus_reset) begin
      st_nxt.cfg = st_r.boot;
    end

    // Pad drivers from the table as it will stand after this edge
    for (int i = 0; i < ugp_pkg::NUM_PINS; i++) begin
      func = st_nxt.cfg[i][ugp_pkg::F_FUNC +: 2];
      pull = st_nxt.cfg[i][ugp_pkg::F_PULL +: 2];
      od   = st_nxt.cfg[i][ugp_pkg::F_OD];
      if (func == ugp_pkg::FN_GPIO) begin
        drive = st_nxt.cfg[i][ugp_pkg::F_DIR];
        val   = st_nxt.cfg[i][ugp_pkg::F_OUT];
      end else begin
        drive = ugp_pkg::ALT_IS_OUT[i];
        case (i)
          // RTS low-active, or half-duplex enable on second choice
          ugp_pkg::PIN_RTS:    val = (func == ugp_pkg::FN_ALT2) ?
                                     ext.de : ~ext.rts_req;
          ugp_pkg::PIN_RS485:  val = ext.de;
          ugp_pkg::PIN_TXT:    val = tx_activity_indicator;
          ugp_pkg::PIN_RXT:    val = rx_activity_indicator;
          ugp_pkg::PIN_STAT_A: val = stat_level(
                                 st_nxt.cfg[ugp_pkg::CFG_STAT_A], ext);
          ugp_pkg::PIN_STAT_B: val = stat_level(
                                 st_nxt.cfg[ugp_pkg::CFG_STAT_B], ext);
          default:             val = 1'b1;
        endcase
      end
      // Open drain only ever pulls low; a high is a released line
      if (drive && od) begin
        st_nxt.pads.out[i] = 1'b0;
        st_nxt.pads.oe[i]  = ~val;
      end else begin
        st_nxt.pads.out[i] = drive & val;
        st_nxt.pads.oe[i]  = drive;
      end
      // pulls held off for the length of bus reset
      // suspend deliberately plays no part here
      // open-drain drivers keep their weak pull-up
      st_nxt.pads.pu[i] = !ext.bus_reset &&
                          ((pull == ugp_pkg::PL_UP) || (drive && od));
      st_nxt.pads.pd[i] = !ext.bus_reset && (pull == ugp_pkg::PL_DOWN);
    end

    // CTS input only when its alternate function is chosen
    st_nxt.core.cts_n = (st_nxt.cfg[ugp_pkg::PIN_CTS][1:0] ==
                         ugp_pkg::FN_ALT1) ? st_r.stab[ugp_pkg::PIN_CTS]
                                           : 1'b1;
    st_nxt.core.carrier_detect_n =
      (st_nxt.cfg[ugp_pkg::PIN_CD][1:0] == ugp_pkg::FN_ALT1) ?
      st_r.stab[ugp_pkg::PIN_CD] : 1'b1;
    // ring indicator or remote wake on the shared pin
    st_nxt.core.ring_indicator_n =
      (st_nxt.cfg[ugp_pkg::PIN_RI][1:0] == ugp_pkg::FN_ALT1) ?
      st_r.stab[ugp_pkg::PIN_RI] : 1'b1;
    st_nxt.core.remote_wake_in_n =
      (st_nxt.cfg[ugp_pkg::PIN_RI][1:0] == ugp_pkg::FN_ALT2) ?
      st_r.stab[ugp_pkg::PIN_RI] : 1'b1;

    // Read data stand for exactly the cycle after the strobe
    st_nxt.rdata = '0;
    if (reg_rd) begin
      if (in_cfg(reg_addr)) begin
        st_nxt.rdata = {24'h00_0000,
                        st_r.cfg[reg_addr[ugp_pkg::IDX_W-1:0]]};
      end else if (reg_addr == ugp_pkg::A_PIN_IN) begin
        st_nxt.rdata = {23'h00_0000, st_r.stab};
      end else if (reg_addr == ugp_pkg::A_STATUS) begin
        st_nxt.rdata = {29'h0000_0000,
                        (st_r.ld != ugp_pkg::LD_DONE),
                        ext.suspend, ext.bus_reset};
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // power-up reset re-arms the loader; the store itself is kept
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  assign reg_rdata = st_r.rdata;
  assign pads      = st_r.pads;
  assign core_in   = st_r.core;

endmodule // ugp_pin_mux

// >>> design/ugp_pkg.sv
/*
  Constants, field layouts, defaults and carrier types for the UART-side
  pin function selector.
  Assumes a single 100 MHz core clock shared by the USB core, the UART
  and this block.
*/
package ugp_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ         = 100_000_000;
  localparam int ACT_TOGGLE_MS  = 100;       // ~10 Hz indicator interval
  localparam int ACT_TOGGLE_CYC = CLK_HZ / 1000 * ACT_TOGGLE_MS;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NUM_PINS = 9;
  localparam int NUM_CFG  = 11;
  localparam int CFG_W    = 8;
  localparam int OTP_W    = 9;               // valid flag above the byte
  localparam int IDX_W    = 4;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;

  // ----------------------------------------------------------------------
  // Pin slots and configuration slots
  // ----------------------------------------------------------------------
  localparam int PIN_RTS    = 0;
  localparam int PIN_CTS    = 1;
  localparam int PIN_RS485  = 2;
  localparam int PIN_TXT    = 3;
  localparam int PIN_RXT    = 4;
  localparam int PIN_CD     = 5;
  localparam int PIN_RI     = 6;
  localparam int PIN_STAT_A = 7;
  localparam int PIN_STAT_B = 8;
  localparam int CFG_STAT_A = 9;             // state_out_a_config
  localparam int CFG_STAT_B = 10;            // state_out_b_config

  // ----------------------------------------------------------------------
  // Pin-type field layout
  // ----------------------------------------------------------------------
  localparam int F_FUNC = 0;                 // two bits
  localparam int F_DIR  = 2;                 // 1 = output in GPIO mode
  localparam int F_OD   = 3;                 // 1 = open drain
  localparam int F_PULL = 4;                 // two bits
  localparam int F_OUT  = 6;                 // GPIO output level

  localparam logic [1:0] FN_GPIO  = 2'h0;
  localparam logic [1:0] FN_ALT1  = 2'h1;
  localparam logic [1:0] FN_ALT2  = 2'h2;
  localparam logic [1:0] PL_UP    = 2'h1;
  localparam logic [1:0] PL_DOWN  = 2'h2;

  // Status-output condition layout
  localparam int ST_C_RESET  = 0;
  localparam int ST_C_SUSP   = 1;
  localparam int ST_C_UNSAFE = 2;
  localparam int ST_POL_HIGH = 3;

  // ----------------------------------------------------------------------
  // Power-up defaults, slot 10 first
  // ----------------------------------------------------------------------
  localparam logic [NUM_CFG-1:0][CFG_W-1:0] CFG_DEFAULT = {
    8'h02, 8'h0a, 8'h0d, 8'h0d, 8'h10, 8'h10,
    8'h05, 8'h05, 8'h05, 8'h11, 8'h0d};

  // Slots whose alternate function is an output
  localparam logic [NUM_PINS-1:0] ALT_IS_OUT = 9'h19d;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_CFG_LAST = 8'h0a;
  localparam logic [ADDR_W-1:0] A_PIN_IN   = 8'h0b;
  localparam logic [ADDR_W-1:0] A_STATUS   = 8'h0c;
  localparam logic [ADDR_W-1:0] A_OTP_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] A_OTP_LAST = 8'h1a;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {LD_REQ, LD_TAKE, LD_DONE} ugp_ld_t;

  typedef logic [NUM_CFG-1:0][CFG_W-1:0] ugp_cfg_arr_t;

  typedef struct packed {
    logic bus_reset;       // USB bus reset in progress
    logic suspend;         // USB suspend
    logic unsafe;          // full configured current not yet allowed
    logic rts_req;         // flow engine asks peer to send
    logic de;              // RS-485 driver enable from the UART
    logic rx_busy;
    logic tx_busy;
  } ugp_ext_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe;
    logic [NUM_PINS-1:0] pu;
    logic [NUM_PINS-1:0] pd;
  } ugp_pads_t;

  typedef struct packed {
    logic cts_n;
    logic carrier_detect_n;
    logic ring_indicator_n;
    logic remote_wake_in_n;
  } ugp_core_in_t;

  typedef struct packed {
    ugp_ld_t             ld;
    logic [IDX_W-1:0]    ld_idx;
    ugp_cfg_arr_t        cfg;
    ugp_cfg_arr_t        boot;
    logic [NUM_PINS-1:0] s1;
    logic [NUM_PINS-1:0] s2;
    logic [NUM_PINS-1:0] s3;
    logic [NUM_PINS-1:0] stab;
    ugp_pads_t           pads;
    ugp_core_in_t        core;
    logic [DATA_W-1:0]   rdata;
  } ugp_top_st_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        lvl;
  } ugp_blink_st_t;

endpackage

// >>> dv/ugp_pad_peer.sv
/*
  Far-side pad peer: resolves each wire from block drive, peer drive
  and weak pulls. Assumes the bench owns drv_en and drv_val.
*/
`timescale 1ns/1ns
module ugp_pad_peer (
  input wire logic         sys_clk,
  input ugp_pkg::ugp_pads_t pads,
  input wire logic [8:0]   drv_en,
  input wire logic [8:0]   drv_val,
  output logic     [8:0]   lvl
);
  // Floating wire wanders so no stale level passes for a drive
  logic fl_r = 1'b0;
  always_ff @(posedge sys_clk) fl_r <= ~fl_r;

  // weak pull-up
  // Block drive wins, then peer, then pulls
  always_comb
    for (int i = 0; i < 9; i++)
      lvl[i] = pads.oe[i] ? pads.out[i] : drv_en[i] ? drv_val[i] :
               pads.pu[i] ? 1'b1 : pads.pd[i] ? 1'b0 : fl_r;
endmodule // ugp_pad_peer

// >>> dv/ugp_pin_mux_bench.sv
/*
  Self-checking bench for the pin selector, one task per scenario.
  Assumes the pad peer model and a 100 MHz clock.
*/
`timescale 1ns/1ns
module ugp_pin_mux_bench;
  logic                  sys_clk;
  logic                  sys_rst;
  logic [7:0]            reg_addr;
  logic [31:0]           reg_wdata;
  logic [31:0]           reg_rdata;
  logic                  reg_wr;
  logic                  reg_rd;
  ugp_pkg::ugp_ext_t     ext;
  ugp_pkg::ugp_pads_t    pads;
  ugp_pkg::ugp_core_in_t core_in;
  logic [8:0]            drv_en;
  logic [8:0]            drv_val;
  logic [8:0]            lvl;
  int                    n_mismatch;
  int                    n_tests;
  // Power-up pin types, slot 0 first
  logic [7:0] dflt [11] = '{8'h0d, 8'h11, 8'h05, 8'h05, 8'h05, 8'h10,
                            8'h10, 8'h0d, 8'h0d, 8'h0a, 8'h02};

  ugp_pin_mux #(.TOGGLE_CYC(8)) DUT (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext(ext), .pad_in(lvl), .pads(pads),
    .core_in(core_in));
  ugp_pad_peer u_peer (.sys_clk(sys_clk), .pads(pads),
    .drv_en(drv_en), .drv_val(drv_val), .lvl(lvl));

  // ----------------
  // Shared tasks
  // ----------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task chk(input string nm, input logic [35:0] e, input logic [35:0] s);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", {28'h0, e}, {4'h0, reg_rdata});
  endtask
  // Loader needs 22 cycles after release; 30 leaves margin
  task rst;
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    w(30);
  endtask
  task pulse(input logic [1:0] on);
    @(posedge sys_clk);
    ext.suspend <= on[0];
    ext.unsafe <= on[1];
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------
  // Scenarios
  // ----------------
  task t_defaults;
    for (int i = 0; i < 11; i++)
      rd(i[7:0], dflt[i]);
    rd(8'h0e, 8'h00);
    w(1);
    chk("pu", 36'h1e3, pads.pu);
    chk("oe", 36'h09c, pads.oe);
    chk("rts wire", 36'h1, lvl[0]);
    $display("t_defaults done");
  endtask
  task t_ext;
    @(posedge sys_clk);
    ext.rts_req <= 1'b1;
    ext.de <= 1'b1;
    pulse(2'h1);
    w(2);
    chk("oe", 36'h11d, pads.oe);
    chk("de out", 36'h1, pads.out[2]);
    chk("pu", 36'h1e3, pads.pu);
    chk("rts wire", 36'h0, lvl[0]);
    pulse(2'h0);
    ext.rts_req <= 1'b0;
    ext.de <= 1'b0;
    $display("t_ext done");
  endtask
  task t_blink;
    int   t[$];
    logic p;
    for (int s = 3; s < 5; s++) begin
      t.delete();
      @(posedge sys_clk);
      ext.tx_busy <= (s == 3);
      ext.rx_busy <= (s == 4);
      w(1);
      p = pads.out[s];
      for (int i = 0; i < 40; i++) begin
        w(1);
        if (pads.out[s] !== p)
          t.push_back(i);
        p = pads.out[s];
      end
      chk("gap", 36'h8, 36'(t.size() > 2 ? t[2] - t[1] : 0));
      @(posedge sys_clk);
      ext.tx_busy <= 1'b0;
      ext.rx_busy <= 1'b0;
      w(4);
      chk("idle", 36'h1, pads.out[s]);
    end
    $display("t_blink done");
  endtask
  task t_inputs;
    int i;
    @(posedge sys_clk);
    drv_en <= 9'h062;
    drv_val <= 9'h000;
    i = 0;
    // Bounded wait for the synchroniser
    while (core_in.cts_n !== 1'b0 && i < 20) begin
      w(1);
      i++;
    end
    if (core_in.cts_n !== 1'b0) begin
      n_mismatch++;
      finish_test();
    end
    w(2);
    chk("core_in", 36'h7, core_in);
    wr(8'h06, 32'h12);
    w(12);
    chk("core_in", 36'h6, core_in);
    wr(8'h05, 32'h11);
    w(12);
    chk("core_in", 36'h2, core_in);
    wr(8'h06, 32'h11);
    w(12);
    chk("core_in", 36'h1, core_in);
    drv_en <= 9'h000;
    $display("t_inputs done");
  endtask
  task t_runtime;
    wr(8'h05, 32'h20);
    w(1);
    chk("pd", 36'h020, pads.pd);
    rd(8'h05, 8'h20);
    wr(8'h02, 32'h44);
    wr(8'h00, 32'h06);
    w(1);
    chk("alt", 36'h7, {pads.oe[0], pads.oe[2], pads.out[2]});
    // Both polarities of suspend and unsafe conditions
    for (int k = 0; k < 4; k++) begin
      wr(8'h09, {28'h0, k[1], ~k[0], k[0], 1'b0});
      pulse({~k[0], k[0]});
      w(2);
      chk("stat on", {35'h0, ~k[1]}, pads.oe[7]);
      pulse(2'h0);
      w(2);
      chk("stat off", {35'h0, k[1]}, pads.oe[7]);
    end
    $display("t_runtime done");
  endtask
  task t_busreset;
    @(posedge sys_clk);
    ext.bus_reset <= 1'b1;
    w(2);
    chk("pulls", 36'h0, {pads.pu, pads.pd});
    wr(8'h06, 32'h20);
    rd(8'h05, 8'h10);
    rd(8'h06, 8'h10);
    rd(8'h09, 8'h0a);
    rd(8'h0c, 8'h01);
    @(posedge sys_clk);
    ext.bus_reset <= 1'b0;
    w(2);
    chk("pu", 36'h1e3, pads.pu);
    $display("t_busreset done");
  endtask
  task t_otp;
    wr(8'h15, 32'h120);
    rd(8'h05, 8'h10);
    rst();
    rd(8'h05, 8'h20);
    w(1);
    chk("pd", 36'h020, pads.pd);
    wr(8'h05, 32'h10);
    ext.bus_reset <= 1'b1;
    w(3);
    @(posedge sys_clk);
    ext.bus_reset <= 1'b0;
    rd(8'h05, 8'h20);
    $display("t_otp done");
  endtask

  initial begin
    n_mismatch = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ext = '0;
    drv_en = 9'h000;
    drv_val = 9'h000;
    rst();
    t_defaults();
    t_ext();
    t_blink();
    t_inputs();
    t_runtime();
    t_busreset();
    t_otp();
    finish_test();
  end
endmodule // ugp_pin_mux_bench

// >>> dv/ugp_pin_mux_properties.sv
/*
  Checker for the pin selector: pulls, default roles, status outputs.
  Assumes one clock; slots never written keep their power-up role.
*/
`timescale 1ns/1ns
module ugp_pin_mux_check #(
  parameter int TOGGLE_CYC = 8
) (
  input wire logic                       sys_clk,
  input wire logic                       sys_rst,
  input wire logic [ugp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ugp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  input ugp_pkg::ugp_ext_t               ext,
  input ugp_pkg::ugp_pads_t              pads
);
  // ----------------
  // Helper state
  // ----------------
  logic [15:0] cust_r = 16'h0000;
  logic [4:0]  age_r;

  // Written slots; kept over reset since one-time words survive it
  always_ff @(posedge sys_clk) begin
    if (reg_wr && reg_addr[7:5] == 3'h0)
      cust_r[reg_addr[3:0]] <= 1'b1;
    age_r <= sys_rst ? 5'h00 : age_r + {4'h0, age_r != 5'h1f};
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Boot loader finished, no write this cycle
  sequence steady;
    age_r == 5'h1f && !reg_wr;
  endsequence
  sequence released;
    $fell(sys_rst) && !ext.bus_reset;
  endsequence
  sequence quiet_susp;
    (age_r == 5'h1f && ext.suspend && !ext.bus_reset && !reg_wr)[*3];
  endsequence
  sequence write_pd;
    age_r == 5'h1f && reg_wr && reg_addr == 8'h05 &&
      reg_wdata[5:4] == 2'h2 && !ext.bus_reset;
  endsequence

  // ----------------
  // Assertions
  // ----------------
  AST_DEFAULT_PULLS: assert property (
    released |=> pads.pu == 9'h1e3 && pads.pd == 9'h000)
    else $error("power-up pulls wrong");
  AST_BUSRST_PULLS_OFF: assert property (
    ext.bus_reset |=> pads.pu == 9'h000 && pads.pd == 9'h000)
    else $error("pulls on during bus reset");
  AST_SUSPEND_KEEPS_PULLS: assert property (
    quiet_susp |-> $stable(pads.pu) && $stable(pads.pd))
    else $error("pulls moved in suspend");
  AST_RS485_DE: assert property (
    steady ##0 !cust_r[2] |=> pads.oe[2] && pads.out[2] == $past(ext.de))
    else $error("direction pin not following de");
  AST_STAT_A_SUSPEND: assert property (
    steady ##0 (!cust_r[7] && !cust_r[9]) |=>
      pads.oe[7] == !$past(ext.suspend) && !pads.out[7])
    else $error("status a wrong");
  AST_STAT_B_SUSPEND: assert property (
    steady ##0 (!cust_r[8] && !cust_r[10]) |=>
      pads.oe[8] == $past(ext.suspend) && !pads.out[8])
    else $error("status b wrong");
  AST_RTS_OPEN_DRAIN: assert property (
    steady ##0 !cust_r[0] |=> pads.oe[0] == $past(ext.rts_req) &&
      !pads.out[0] && (pads.pu[0] || $past(ext.bus_reset)))
    else $error("rts pin wrong");
  AST_WRITE_APPLIES: assert property (
    write_pd |=> pads.pd[5])
    else $error("pin type write late");
endmodule // ugp_pin_mux_check

bind ugp_pin_mux ugp_pin_mux_check #(.TOGGLE_CYC(TOGGLE_CYC)) u_check (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .ext(ext), .pads(pads));
